// ===== dv/modem_model.sv
`timescale 1ns/1ps
// ****************************************
// Modem side model
// ****************************************
module modem_model (
  input wire logic sys_clk_i,
  input wire logic ring_cmd_i,
  input wire logic clk16_run_i,
  output logic ring_indicator_o,
  output logic rx_clk16_o,
  output logic serial_input_o
);
  // Lines change just after the edge, like a real data set
  always @(posedge sys_clk_i) begin
    ring_indicator_o <= ring_cmd_i;
    // external 16x clock
    // Clock stands still outside bursts, never free running
    rx_clk16_o <= clk16_run_i ? ~rx_clk16_o : 1'b0;
    // Nothing to send, so the line marks
    serial_input_o <= 1'b1;
  end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "modem_pins_regs.svh"
// ****************************************
// Bench top
// ****************************************
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb;
  logic sys_clk = 1'b0; // 100 ns period
  logic rst_n = 1'b0; // Held low three cycles
  logic mrst = 1'b0; // Master reset pin
  logic ce = 1'b1; // Clock enable
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic ring_cmd = 1'b0, run16 = 1'b0;
  logic ring, clk16, serial_input, tick, out_a_n, out_b_n, rts_n, serial_output, irq, ack;
  logic [31:0] rdat, d;
  int fails = 0, compares = 0, ticks = 0;
  always #50 sys_clk = ~sys_clk;
  // Small oversample keeps the tick count quick to reach
  modem_control_status_pins #(.OVERSAMPLE(4)) modem_control_status_pins_i (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(ce), .master_reset_pin_i(mrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ring_indicator_i(ring),
    .rx_clk16_i(clk16), .serial_input_i(serial_input), .rx_bit_tick_o(tick),
    .user_output_a_n_o(out_a_n), .user_output_b_n_o(out_b_n), .rts_n_o(rts_n),
    .serial_output_o(serial_output), .interrupt_output_o(irq));
  modem_model modem_model_i (.sys_clk_i(sys_clk), .ring_cmd_i(ring_cmd), .clk16_run_i(run16),
    .ring_indicator_o(ring), .rx_clk16_o(clk16), .serial_input_o(serial_input));
  // Count receiver bit ticks
  always @(posedge sys_clk) if (tick === 1'b1) ticks <= ticks + 1;
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One classic Wishbone cycle; bounded wait for ack
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] v, output logic [31:0] r);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, v};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      end_of_test();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Let a few edges land, then sample off the edge
  task automatic settle(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_reset;
    `CHK("serial_output", 1'b1, serial_output)
    `CHK("out_a", 1'b1, out_a_n)
    `CHK("out_b", 1'b1, out_b_n)
    `CHK("rts", 1'b1, rts_n)
    `CHK("irq", 1'b0, irq)
  endtask
  // Nine 16x rises: two ticks, phase left at one
  task automatic t_tick;
    @(posedge sys_clk);
    run16 <= 1'b1;
    settle(16);
    @(posedge sys_clk);
    run16 <= 1'b0;
    settle(6);
    `CHK("ticks", 2, ticks)
    // Frozen enable: a burst must not count at all
    @(posedge sys_clk);
    ce <= 1'b0;
    run16 <= 1'b1;
    settle(16);
    @(posedge sys_clk);
    run16 <= 1'b0;
    settle(2);
    @(posedge sys_clk);
    ce <= 1'b1;
    settle(1);
    `CHK("frozen ticks", 2, ticks)
    xfer(`OFF_RX_COUNT, 1'b0, 8'h00, d);
    `CHK("phase", 32'h81, d)
  endtask
  task automatic t_ctrl;
    xfer(`OFF_MODEM_CTRL, 1'b1, 8'h0e, d);
    settle(2);
    `CHK("out_a", 1'b0, out_a_n)
    `CHK("out_b", 1'b0, out_b_n)
    `CHK("rts", 1'b0, rts_n)
    xfer(`OFF_MODEM_CTRL, 1'b1, 8'h0a, d);
    settle(2);
    `CHK("out_a", 1'b1, out_a_n)
    `CHK("out_b", 1'b0, out_b_n)
    xfer(`OFF_MODEM_CTRL, 1'b1, 8'h1e, d);
    settle(2);
    `CHK("loop", 3'b111, {out_a_n, out_b_n, rts_n})
    xfer(`OFF_MODEM_STAT, 1'b0, 8'h00, d);
    `CHK("loop ring", 1'b1, d[6])
    xfer(`OFF_MODEM_CTRL, 1'b1, 8'h0e, d);
    mrst <= 1'b1;
    settle(2);
    `CHK("mrst", 4'hf, {out_a_n, out_b_n, rts_n, serial_output})
    @(posedge sys_clk);
    mrst <= 1'b0;
    xfer(`OFF_MODEM_CTRL, 1'b0, 8'h00, d);
    `CHK("ctrl", 32'h0, d)
    xfer(8'h20, 1'b0, 8'h00, d);
    `CHK("unmapped", 32'h0, d)
  endtask
  task automatic t_ring;
    xfer(`OFF_INT_ENABLE, 1'b1, 8'h08, d);
    xfer(`OFF_IRQ_MASK, 1'b1, 8'h01, d);
    ring_cmd <= 1'b1;
    settle(4);
    `CHK("irq", 1'b1, irq)
    xfer(`OFF_MODEM_STAT, 1'b0, 8'h00, d);
    `CHK("stat", 2'b11, {d[6], d[2]})
    xfer(`OFF_MODEM_STAT, 1'b0, 8'h00, d);
    `CHK("rearm", 2'b10, {d[6], d[2]})
    xfer(`OFF_IRQ_STAT, 1'b0, 8'h00, d);
    `CHK("isr", 1'b1, d[0])
    settle(2);
    `CHK("irq", 1'b0, irq)
    xfer(`OFF_INT_ENABLE, 1'b1, 8'h00, d);
    ring_cmd <= 1'b0;
    settle(3);
    @(posedge sys_clk);
    ring_cmd <= 1'b1;
    settle(4);
    `CHK("irq off", 1'b0, irq)
    @(posedge sys_clk);
    ring_cmd <= 1'b0;
    settle(4);
    xfer(`OFF_MODEM_STAT, 1'b0, 8'h00, d);
    `CHK("stat", 2'b01, {d[6], d[2]})
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle(1);
    t_reset();
    t_tick();
    t_ctrl();
    t_ring();
    end_of_test();
  end
endmodule

// ===== rtl/modem_control_status_pins.sv
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "modem_pins_regs.svh"
// Summary of operation
// - Control bit high drives user output low
// - User outputs high on reset, loop, clear
// - Receiver timed from external 16x clock
// - Status bit 6 shows ring level
// - Status bit 2 flags ring rise
// - Enabled ring rise raises interrupt
// - Request-to-send follows bit 1, forced high in loop
// - Serial output marks after master reset
// - Status read re-arms change detection
// - Interrupt cleared by service or reset
module modem_control_status_pins
  import modem_pins_pkg::*;
#(
  parameter int OVERSAMPLE = `RX_OVERSAMPLE
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic master_reset_pin_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ring_indicator_i,
  input wire logic rx_clk16_i,
  input wire logic serial_input_i,
  output logic rx_bit_tick_o,
  output logic user_output_a_n_o,
  output logic user_output_b_n_o,
  output logic rts_n_o,
  output logic serial_output_o,
  output logic interrupt_output_o
);

  // ****************************************
  // Parameter check
  // ****************************************
  // Counter below is four bits wide
  if (OVERSAMPLE < 2 || OVERSAMPLE > 16) begin : g_bad_os
    $error("OVERSAMPLE must be 2 to 16");
  end

  localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);

  // ****************************************
  // State
  // ****************************************
  bus_state_t bus_reg, bus_next;         // Handshake phase
  logic ack_reg, ack_next;               // Bus answer
  logic [31:0] rdat_reg, rdat_next;      // Captured read data
  modem_ctrl_t mcr_reg, mcr_next;        // modem_control_reg
  logic [7:0] ier_reg, ier_next;         // Interrupt enables
  logic [7:0] imask_reg, imask_next;     // Interrupt mask
  logic [7:0] istat_reg, istat_next;     // Sticky interrupt status
  logic flag_reg, flag_next;             // ring_rise_flag
  logic ring_prev_reg, ring_prev_next;   // Ring level last cycle
  logic clk16_prev_reg, clk16_prev_next; // Receiver clock last cycle
  logic [3:0] rxcnt_reg, rxcnt_next;     // 16x phase counter
  logic tick_reg, tick_next;             // Bit boundary pulse
  logic [3:0] pins_reg, pins_next;       // rts, out a, out b, serial_output
  logic irq_reg, irq_next;               // interrupt_output
  logic sin_reg, sin_next;               // serial_input sample

  // ****************************************
  // Derived combinational terms
  // ****************************************
  wb_req_t req;
  logic clr;          // Master or bus reset
  logic ring_now;     // Ring level as seen inside
  logic ring_rise;    // Low to high this cycle
  logic acc_wr;       // Write takes effect now
  logic acc_rd;       // Read side effect now
  logic [7:0] rd_byte;

  assign req = '{adr: wb_adr_i, dat: wb_dat_i[7:0], we: wb_we_i, sel0: wb_sel_i[0]};
  assign clr = !rst_n_i || master_reset_pin_i;
  // Loop mode feeds user output a back as ring
  assign ring_now = mcr_reg.loop ? mcr_reg.out_a : ring_indicator_i;
  assign ring_rise = ring_now && !ring_prev_reg;
  // Side effects only at the acknowledging edge
  assign acc_wr = ack_reg && wb_cyc_i && wb_stb_i && req.we;
  assign acc_rd = ack_reg && wb_cyc_i && wb_stb_i && !req.we;

  // ****************************************
  // Read mux
  // ****************************************
  // Selects the byte for the addressed register
  always_comb begin
    rd_byte = `RST_BYTE;
    unique case (req.adr)
      `OFF_MODEM_CTRL: rd_byte = mcr_reg;
      `OFF_MODEM_STAT: begin
        rd_byte[`BIT_RING_LEVEL] = ring_now;
        rd_byte[`BIT_RING_RISE] = flag_reg;
      end
      `OFF_INT_ENABLE: rd_byte = ier_reg;
      `OFF_IRQ_STAT: rd_byte = istat_reg;
      `OFF_IRQ_MASK: rd_byte = imask_reg;
      `OFF_RX_COUNT: begin
        // Phase count low, sampled serial line on top
        rd_byte[$bits(rxcnt_reg)-1:0] = rxcnt_reg;
        rd_byte[`BIT_SIN_LEVEL] = sin_reg;
      end
      // Unmapped reads return zero
      default: rd_byte = `RST_BYTE;
    endcase
  end

  // ****************************************
  // Wishbone handshake
  // ****************************************
  // One wait cycle, ack for one cycle
  always_comb begin
    bus_next = bus_reg;
    ack_next = 1'b0;
    rdat_next = rdat_reg;
    unique case (bus_reg)
      BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          bus_next = BUS_ACK;
          ack_next = 1'b1;
          rdat_next = {24'h0, rd_byte};
        end
      end
      BUS_ACK: begin
        // Master drops stb after ack
        bus_next = BUS_IDLE;
      end
    endcase
  end

  // ****************************************
  // Control and status registers
  // ****************************************
  // Writes, sticky flags and read clears
  always_comb begin
    mcr_next = mcr_reg;
    ier_next = ier_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    flag_next = flag_reg;
    if (acc_wr && req.sel0) begin
      unique case (req.adr)
        `OFF_MODEM_CTRL: mcr_next = req.dat;
        `OFF_INT_ENABLE: ier_next = req.dat;
        `OFF_IRQ_MASK: imask_next = req.dat;
        default: ;
      endcase
    end
    // read clears only what was reported
    if (acc_rd && req.adr == `OFF_MODEM_STAT && rdat_reg[`BIT_RING_RISE]) begin
      flag_next = 1'b0;
    end
    if (acc_rd && req.adr == `OFF_IRQ_STAT) begin
      istat_next = istat_reg & ~rdat_reg[7:0];
    end
    if (ring_rise) begin
      flag_next = 1'b1;
    end
    if (ring_rise && ier_reg[`BIT_MSI_EN]) begin
      istat_next[`BIT_IRQ_RING] = 1'b1;
    end
  end

  // ****************************************
  // Receiver 16x clock
  // ****************************************
  // Edge counting on the sampled 16x clock
  always_comb begin
    clk16_prev_next = rx_clk16_i;
    rxcnt_next = rxcnt_reg;
    tick_next = 1'b0;
    sin_next = serial_input_i;
    if (rx_clk16_i && !clk16_prev_reg) begin
      if (rxcnt_reg == OS_LAST) begin
        rxcnt_next = 4'h0;
        tick_next = 1'b1;
      end else begin
        rxcnt_next = rxcnt_reg + 4'h1;
      end
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  // Active low pins, forced high in loop
  always_comb begin
    ring_prev_next = ring_now;
    pins_next[3] = !(mcr_next.rts && !mcr_next.loop);
    pins_next[2] = !(mcr_next.out_a && !mcr_next.loop);
    // out b forced high in loop
    pins_next[1] = !(mcr_next.out_b && !mcr_next.loop);
    // No transmitter here: line stays marking
    pins_next[0] = `SERIAL_OUTPUT_MARK;
    irq_next = |(istat_next & imask_next);
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset ahead of clock enable; master reset too
  always_ff @(posedge sys_clk_i) begin
    if (clr) begin
      bus_reg <= BUS_IDLE;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
      mcr_reg <= `RST_BYTE;
      ier_reg <= `RST_BYTE;
      imask_reg <= `RST_BYTE;
      istat_reg <= `RST_BYTE;
      flag_reg <= 1'b0;
      ring_prev_reg <= 1'b0;
      clk16_prev_reg <= 1'b0;
      rxcnt_reg <= 4'h0;
      tick_reg <= 1'b0;
      pins_reg <= {`PIN_INACTIVE, `PIN_INACTIVE, `PIN_INACTIVE, `SERIAL_OUTPUT_MARK};
      irq_reg <= 1'b0;
      sin_reg <= 1'b1;
    end else if (ce_i) begin
      bus_reg <= bus_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      mcr_reg <= mcr_next;
      ier_reg <= ier_next;
      imask_reg <= imask_next;
      istat_reg <= istat_next;
      flag_reg <= flag_next;
      ring_prev_reg <= ring_prev_next;
      clk16_prev_reg <= clk16_prev_next;
      rxcnt_reg <= rxcnt_next;
      tick_reg <= tick_next;
      pins_reg <= pins_next;
      irq_reg <= irq_next;
      sin_reg <= sin_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign rx_bit_tick_o = tick_reg;
  assign rts_n_o = pins_reg[3];
  assign user_output_a_n_o = pins_reg[2];
  assign user_output_b_n_o = pins_reg[1];
  assign serial_output_o = pins_reg[0];
  assign interrupt_output_o = irq_reg;

  // ****************************************
  // Checks
  // ****************************************
  out_a_active_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    (ce_i && mcr_next.out_a && !mcr_next.loop) |=> !user_output_a_n_o)
    else $error("user output a not low");
  out_b_loop_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    mcr_reg.loop |-> user_output_b_n_o && user_output_a_n_o)
    else $error("user outputs low in loop");
  ring_level_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    (ce_i && bus_reg == BUS_IDLE && wb_stb_i && wb_cyc_i && req.adr == `OFF_MODEM_STAT)
      |=> wb_ack_o && wb_dat_o[`BIT_RING_LEVEL] == $past(ring_now))
    else $error("ring level misreported");
  ring_flag_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    (ce_i && ring_rise) |=> flag_reg)
    else $error("ring rise not flagged");
  ring_irq_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    (ce_i && ring_rise && ier_reg[`BIT_MSI_EN] && imask_reg[`BIT_IRQ_RING] && !acc_wr)
      |=> istat_reg[`BIT_IRQ_RING] && interrupt_output_o)
    else $error("ring interrupt missing");
  rts_follow_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    (ce_i && !acc_wr) |=> rts_n_o == !(mcr_reg.rts && !mcr_reg.loop))
    else $error("rts wrong level");
  serial_output_mark_a: assert property (@(posedge sys_clk_i)
    $past(master_reset_pin_i) |-> serial_output_o && rts_n_o && !interrupt_output_o)
    else $error("pins not idle after reset");
  flag_rearm_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    (ce_i && acc_rd && req.adr == `OFF_MODEM_STAT && rdat_reg[`BIT_RING_RISE] && !ring_rise)
      |=> !flag_reg)
    else $error("flag not re-armed");
  irq_service_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    (ce_i && acc_rd && req.adr == `OFF_IRQ_STAT && !ring_rise && rdat_reg[7:0] == istat_reg)
      |=> !interrupt_output_o)
    else $error("interrupt not cleared");
  // Counter wraps exactly on the last phase edge
  tick_spacing_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    (ce_i && rx_clk16_i && !clk16_prev_reg && rxcnt_reg == OS_LAST) |=> rx_bit_tick_o && rxcnt_reg == 4'h0)
    else $error("bit tick misplaced");
  // Low enable must not move the receiver phase
  rx_freeze_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    !ce_i |=> $stable(rxcnt_reg) && $stable(rx_bit_tick_o))
    else $error("receiver phase moved while frozen");
  // Loop mode reads user output a back as ring
  loop_ring_a: assert property (@(posedge sys_clk_i) disable iff (clr)
    (ce_i && bus_reg == BUS_IDLE && wb_cyc_i && wb_stb_i && req.adr == `OFF_MODEM_STAT && mcr_reg.loop)
      |=> wb_dat_o[`BIT_RING_LEVEL] == $past(mcr_reg.out_a))
    else $error("loop ring level wrong");

endmodule

// ===== rtl/modem_pins_pkg.sv
package modem_pins_pkg;
  // Wishbone request as seen by the slave
  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] dat;
    logic we;
    logic sel0;
  } wb_req_t;
  // Modem control byte layout
  typedef struct packed {
    logic [2:0] spare;
    logic loop;
    logic out_b;
    logic out_a;
    logic rts;
    logic term;
  } modem_ctrl_t;
  // Bus handshake states
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;
endpackage

// ===== rtl/modem_pins_regs.svh
`ifndef MODEM_PINS_REGS_SVH
`define MODEM_PINS_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFF_MODEM_CTRL 8'h00
`define OFF_MODEM_STAT 8'h04
`define OFF_INT_ENABLE 8'h08
`define OFF_IRQ_STAT 8'h0c
`define OFF_IRQ_MASK 8'h10
`define OFF_RX_COUNT 8'h14
// ****************************************
// Field positions
// ****************************************
`define BIT_RTS 1
`define BIT_OUT_A 2
`define BIT_OUT_B 3
`define BIT_LOOP 4
`define BIT_RING_RISE 2
`define BIT_RING_LEVEL 6
`define BIT_MSI_EN 3
`define BIT_IRQ_RING 0
`define BIT_SIN_LEVEL 7
// ****************************************
// Reset and idle values
// ****************************************
`define RST_BYTE 8'h00
`define SERIAL_OUTPUT_MARK 1'b1
`define PIN_INACTIVE 1'b1
`define RX_OVERSAMPLE 16
`endif
